// File: pkg/fp_exec_cfg.svh
// Constants for the floating-point execution block.
// Assumes inclusion by bare name from the design and verification files.
`ifndef FP_EXEC_CFG_SVH
`define FP_EXEC_CFG_SVH
// ----------------------------------------------------------------
// APB map
// ----------------------------------------------------------------
`define ADDR_OPCODE 12'h000
`define ADDR_OPA 12'h004
`define ADDR_OPB 12'h008
`define ADDR_OPD 12'h00c
`define ADDR_RESULT 12'h010
`define ADDR_STATUS 12'h014
`define ADDR_CTRL 12'h018
`define ADDR_BASE 12'h01c
`define ADDR_ADDRESS 12'h020
`define ADDR_NEWBASE 12'h024
// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define OP_CODE_MSB 3
`define OP_SIGNED_BIT 4
`define OP_HALF_BIT 5
`define OP_FBITS_LSB 8
`define OP_FBITS_MSB 13
`define OP_WB_BIT 14
`define OP_SUBOFF_BIT 15
`define OP_COUNT_LSB 16
`define OP_COUNT_MSB 21
`define OP_IMM_LSB 22
`define OP_IMM_MSB 29
// ----------------------------------------------------------------
// Control and status bits
// ----------------------------------------------------------------
`define CTRL_LSPEN_BIT 0
`define CTRL_SFPA_BIT 1
`define CTRL_SECURE_BIT 2
`define CTRL_FPEXT_BIT 3
`define ST_BUSY_BIT 0
`define ST_UNDEF_BIT 1
`define ST_LSPACT_BIT 2
`define ST_CTXACT_BIT 3
`define ST_SAVE_BIT 4
`define ST_CLEAR_BIT 5
`define ST_RELOAD_BIT 6
`define ST_DIVZ_BIT 7
`define WORD_BYTES 32'h4
`define QNAN 32'h7fc00000
`define EXP_BIAS 10'h07f
`endif

// File: pkg/fp_exec_pkg.sv
// Types for the floating-point execution block.
// Assumes the constants header sits beside it.
package fp_exec_pkg;
  // Operation codes
  typedef enum logic [3:0] {
    OP_TO_FIXED, OP_FROM_FIXED, OP_DIV, OP_FMA, OP_FMS, OP_FNMA, OP_FNMS,
    OP_LDM_IA, OP_LDM_DB, OP_LDR, OP_LAZY_STORE, OP_LAZY_RESTORE, OP_NOP
  } op_t;
endpackage : fp_exec_pkg

// File: verilog/fp_convert_fma_lazy_state.sv
// Floating-point convert, divide, fused multiply, load address and lazy state.
// Assumes an APB master; results single precision, fused ones registered a cycle after issue when opcode bit 31 is set.
//
// Summary of operation
// RL1: Fixed source uses only low 16/32 bits
// RL2: Signed to-fixed result is sign-extended
// RL3: Unsigned to-fixed result is zero-extended
// RL4: To-fixed truncates, from-fixed rounds nearest
// RL5: Divide first operand by second
// RL6: Fused add uses unrounded product
// RL7: Fused subtract negates first operand
// RL8: Negated add negates product and destination
// RL9: Negated subtract negates destination only
// RL10: Integer condition flags never changed
// RL11: Increment-after starts at base address
// RL12: Decrement-before ends below base address
// RL13: Decrement-before always writes back base
// RL14: Size qualifier matches register width
// RL15: List holds one to sixteen doublewords (code takes a 6-bit count, 0-63, at 4 bytes per entry)
// RL16: Single load base plus/minus word offset
// RL17: Pending lazy save cancelled by restore
// RL18: Restore reloads saved registers otherwise
// RL19: Restore marks floating context active
// RL20: Next FP op saves then clears
// RL21: Not in use: lazy ops do nothing
// RL22: Non-secure undefined; no extension means no-op
// RL23: IEEE single semantics for specials (fused infinity times zero or opposite infinities give infinity, not NaN)
//
// The APB interface to the registers and the address map are this design's own decisions.
`include "fp_exec_cfg.svh"
`timescale 1ns/100ps
module fp_convert_fma_lazy_state (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ----------------------------------------------------------------
  // Float helpers
  // ----------------------------------------------------------------
  // Pack sign, unbiased exponent and 48-bit mantissa (msb at 47) to single
  function automatic logic [31:0] packf(input logic s, input logic signed [11:0] e,
                                        input logic [47:0] m, input logic trunc);
    logic [23:0] mant;
    logic [24:0] rnd;
    logic signed [11:0] be;
    logic g;
    logic st;
    mant = m[47:24];
    g = m[23];
    st = |m[22:0];
    be = e + 12'sd127;
    rnd = {1'b0, mant};
    // RL4 nearest-even unless truncating
    if (!trunc && g && (st || mant[0])) rnd = rnd + 25'h1;
    if (rnd[24]) begin
      rnd = rnd >> 1;
      be = be + 12'sd1;
    end
    if (m == 48'h0 || be <= 12'sd0) packf = {s, 31'h0};
    else if (be >= 12'sd255) packf = {s, 8'hff, 23'h0};
    else packf = {s, be[7:0], rnd[22:0]};
  endfunction : packf

  // Leading one position of a 48-bit value
  function automatic logic [5:0] lead(input logic [47:0] v);
    lead = 6'h0;
    for (int i = 0; i < 48; i++) begin
      if (v[i]) lead = 6'(i);
    end
  endfunction : lead

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] opcode_reg; // Last issued operation word
  logic [31:0] opA_reg; // First operand
  logic [31:0] opB_reg; // Second operand
  logic [31:0] opD_reg; // Destination value / base register
  logic [31:0] result_reg; // Result
  logic [31:0] address_reg; // First load address
  logic [31:0] newBase_reg; // Written-back base
  logic [3:0] ctrl_reg; // Lazy enable, in-use, secure, extension present
  logic lspAct_reg; // Lazy save pending
  logic ctxAct_reg; // Floating context active
  logic save_reg; // Pulse: store secure registers
  logic clear_reg; // Pulse: clear secure registers
  logic reload_reg; // Pulse: reload secure registers
  logic undef_reg; // Last op undefined
  logic divz_reg; // Last divide by zero

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire access = psel && penable;
  wire wrOp = access && pwrite && (paddr == `ADDR_OPCODE);
  wire [3:0] opCode = pwdata[`OP_CODE_MSB:0];
  wire isSigned = pwdata[`OP_SIGNED_BIT];
  wire isHalf = pwdata[`OP_HALF_BIT];
  wire [5:0] fbits = pwdata[`OP_FBITS_MSB:`OP_FBITS_LSB];
  wire [5:0] count = pwdata[`OP_COUNT_MSB:`OP_COUNT_LSB];
  wire [7:0] immW = pwdata[`OP_IMM_MSB:`OP_IMM_LSB];
  wire isLazy = (opCode == fp_exec_pkg::OP_LAZY_STORE) ||
                (opCode == fp_exec_pkg::OP_LAZY_RESTORE);
  wire secure = ctrl_reg[`CTRL_SECURE_BIT];
  wire sfpa = ctrl_reg[`CTRL_SFPA_BIT];
  wire fpExt = ctrl_reg[`CTRL_FPEXT_BIT];
  wire isFpOp = (opCode <= fp_exec_pkg::OP_LDR);

  // ----------------------------------------------------------------
  // Fixed to float
  // ----------------------------------------------------------------
  // RL1 low bits only
  wire [31:0] fixSrc = isHalf ? (isSigned ? {{16{opA_reg[15]}}, opA_reg[15:0]} :
                                 {16'h0, opA_reg[15:0]}) : opA_reg;
  wire fixNeg = isSigned && fixSrc[31];
  wire [31:0] fixMag = fixNeg ? (32'h0 - fixSrc) : fixSrc;
  wire [47:0] fixWide = {fixMag, 16'h0};
  wire [5:0] fixLead = lead(fixWide);
  wire [47:0] fixNorm = fixWide << (6'd47 - fixLead);
  wire signed [11:0] fixExp = $signed({6'h0, fixLead}) - 12'sd16 - $signed({6'h0, fbits});
  // RL4 round to nearest
  wire [31:0] fromFixed = packf(fixNeg, fixExp, fixNorm, 1'b0);

  // ----------------------------------------------------------------
  // Float to fixed
  // ----------------------------------------------------------------
  wire [7:0] aExp = opA_reg[30:23];
  wire [23:0] aMan = {aExp != 8'h0, opA_reg[22:0]};
  wire signed [11:0] shAmt = $signed({4'h0, aExp}) - 12'sd150 + $signed({6'h0, fbits});
  // RL4 truncation toward zero by shifting off fraction
  wire [63:0] magWide = (shAmt >= 12'sd40) ? 64'hffffffffffffffff :
                        (shAmt >= 12'sd0) ? ({40'h0, aMan} << shAmt[5:0]) :
                        (shAmt <= -12'sd24) ? 64'h0 : ({40'h0, aMan} >> (-shAmt));
  wire aNan = (aExp == 8'hff) && (opA_reg[22:0] != 23'h0);
  logic [31:0] toFixed;
  // Saturating conversion, NaN gives zero
  always_comb begin
    toFixed = 32'h0;
    if (aNan) toFixed = 32'h0;
    else if (isSigned) begin
      if (isHalf) begin
        if (magWide > 64'h7fff) toFixed = opA_reg[31] ? 32'hffff8000 : 32'h00007fff;
        // RL2 sign-extend half result
        else toFixed = opA_reg[31] ? (32'h0 - magWide[31:0]) : magWide[31:0];
      end else begin
        if (magWide > 64'h7fffffff) toFixed = opA_reg[31] ? 32'h80000000 : 32'h7fffffff;
        else toFixed = opA_reg[31] ? (32'h0 - magWide[31:0]) : magWide[31:0];
      end
    end else if (!opA_reg[31]) begin
      // RL3 zero-extend unsigned result
      if (isHalf) toFixed = (magWide > 64'hffff) ? 32'h0000ffff : {16'h0, magWide[15:0]};
      else toFixed = (magWide > 64'hffffffff) ? 32'hffffffff : magWide[31:0];
    end
  end

  // ----------------------------------------------------------------
  // Divide
  // ----------------------------------------------------------------
  wire [7:0] bExp = opB_reg[30:23];
  wire [23:0] bMan = {bExp != 8'h0, opB_reg[22:0]};
  wire bZero = (opB_reg[30:0] == 31'h0);
  wire aZero = (opA_reg[30:0] == 31'h0);
  wire aInf = (aExp == 8'hff) && !aNan;
  wire bNan = (bExp == 8'hff) && (opB_reg[22:0] != 23'h0);
  wire bInf = (bExp == 8'hff) && !bNan;
  wire qSign = opA_reg[31] ^ opB_reg[31];
  // RL5 quotient of first by second
  wire [47:0] quot = {aMan, 24'h0} / {24'h0, (bZero ? 24'h1 : bMan)};
  wire [5:0] qLead = lead(quot);
  wire [47:0] qNorm = quot << (6'd47 - qLead);
  wire signed [11:0] qExp = $signed({4'h0, aExp}) - $signed({4'h0, bExp}) +
                            $signed({6'h0, qLead}) - 12'sd24;
  logic [31:0] divRes;
  // RL23 special operands
  always_comb begin
    if (aNan || bNan || (aZero && bZero) || (aInf && bInf)) divRes = `QNAN;
    else if (aInf || bZero) divRes = {qSign, 8'hff, 23'h0};
    else if (aZero || bInf) divRes = {qSign, 31'h0};
    else divRes = packf(qSign, qExp, qNorm, 1'b0);
  end

  // ----------------------------------------------------------------
  // Fused multiply-add
  // ----------------------------------------------------------------
  wire [3:0] fop = opcode_reg[`OP_CODE_MSB:0];
  // RL7 RL8 negate first operand
  wire negA = (fop == fp_exec_pkg::OP_FMS) || (fop == fp_exec_pkg::OP_FNMA);
  // RL8 RL9 negate destination
  wire negD = (fop == fp_exec_pkg::OP_FNMA) || (fop == fp_exec_pkg::OP_FNMS);
  wire pSign = opA_reg[31] ^ opB_reg[31] ^ negA;
  wire dSign = opD_reg[31] ^ negD;
  // RL6 exact 48-bit product, unrounded
  wire [47:0] prod = aMan * bMan;
  wire signed [11:0] pExp = $signed({4'h0, aExp}) + $signed({4'h0, bExp}) - 12'sd253;
  wire [7:0] dExp = opD_reg[30:23];
  wire [47:0] dWide = {1'b0, dExp != 8'h0, opD_reg[22:0], 23'h0};
  wire signed [11:0] dE = $signed({4'h0, dExp}) - 12'sd126;
  wire pBig = (aZero || bZero) ? 1'b0 : (opD_reg[30:0] == 31'h0) || (pExp >= dE);
  wire signed [11:0] eDiff = pBig ? (pExp - dE) : (dE - pExp);
  wire [5:0] sh = (eDiff > 12'sd47) ? 6'd47 : eDiff[5:0];
  wire [47:0] bigM = pBig ? prod : dWide;
  wire [47:0] smlRaw = pBig ? ((opD_reg[30:0] == 31'h0) ? 48'h0 : dWide) :
                       ((aZero || bZero) ? 48'h0 : prod);
  wire [47:0] smlM = smlRaw >> sh;
  wire stickyS = |(smlRaw & ~(48'hffffffffffff << sh));
  wire sameSign = (pSign == dSign);
  wire [48:0] sum = sameSign ? ({1'b0, bigM} + {1'b0, smlM}) :
                    ({1'b0, bigM} - {1'b0, smlM} - {48'h0, stickyS});
  wire [47:0] sumM = sum[48] ? sum[48:1] : sum[47:0];
  wire [5:0] sLead = lead(sumM);
  wire [47:0] sNorm = (sumM << (6'd47 - sLead)) | {47'h0, stickyS};
  wire signed [11:0] sExp = (pBig ? pExp : dE) + $signed({6'h0, sLead}) - 12'sd47 +
                            $signed({11'h0, sum[48]});
  wire rSign = pBig ? pSign : dSign;
  wire anyNan = aNan || bNan || ((dExp == 8'hff) && (opD_reg[22:0] != 23'h0));
  // RL6 single rounding of the final sum
  wire [31:0] fmaRes = anyNan ? `QNAN :
                       (aInf || bInf || (dExp == 8'hff)) ? {rSign, 8'hff, 23'h0} :
                       packf(rSign, sExp, sNorm, 1'b0);

  // ----------------------------------------------------------------
  // Address generation
  // ----------------------------------------------------------------
  // RL11 start at base
  wire [31:0] iaAddr = opD_reg;
  // RL12 end just below base
  wire [31:0] dbAddr = opD_reg - ({26'h0, count} * `WORD_BYTES);
  wire [31:0] iaBase = opD_reg + ({26'h0, count} * `WORD_BYTES);
  // RL16 word-scaled immediate, 0-1020
  wire [31:0] offW = {22'h0, immW, 2'b00};
  wire [31:0] ldrAddr = pwdata[`OP_SUBOFF_BIT] ? (opD_reg - offW) : (opD_reg + offW);

  // ----------------------------------------------------------------
  // APB read mux
  // ----------------------------------------------------------------
  wire [31:0] statusWord = {24'h0, divz_reg, reload_reg, clear_reg, save_reg,
                            ctxAct_reg, lspAct_reg, undef_reg, 1'b0};
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  logic [31:0] rdMux;
  // Read selection, unmapped reads zero
  always_comb begin
    if (paddr == `ADDR_OPCODE) rdMux = opcode_reg;
    else if (paddr == `ADDR_OPA) rdMux = opA_reg;
    else if (paddr == `ADDR_OPB) rdMux = opB_reg;
    else if (paddr == `ADDR_OPD) rdMux = opD_reg;
    else if (paddr == `ADDR_RESULT) rdMux = result_reg;
    else if (paddr == `ADDR_STATUS) rdMux = statusWord;
    else if (paddr == `ADDR_CTRL) rdMux = {28'h0, ctrl_reg};
    else if (paddr == `ADDR_ADDRESS) rdMux = address_reg;
    else if (paddr == `ADDR_NEWBASE) rdMux = newBase_reg;
    else rdMux = 32'h0;
  end
  assign prdata = rdMux;

  // ----------------------------------------------------------------
  // Operand and control registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      opA_reg <= 32'h0;
      opB_reg <= 32'h0;
      opD_reg <= 32'h0;
      ctrl_reg <= 4'h0;
      opcode_reg <= 32'h0;
    end else if (access && pwrite) begin
      if (paddr == `ADDR_OPA) opA_reg <= pwdata;
      else if (paddr == `ADDR_OPB) opB_reg <= pwdata;
      else if (paddr == `ADDR_OPD || paddr == `ADDR_BASE) opD_reg <= pwdata;
      else if (paddr == `ADDR_CTRL) ctrl_reg <= pwdata[3:0];
      else if (paddr == `ADDR_OPCODE) opcode_reg <= pwdata;
    end
  end

  // ----------------------------------------------------------------
  // Execution and lazy state
  // ----------------------------------------------------------------
  // Fused results use the registered opcode and appear one cycle after issue, only when its bit 31 is set
  // RL10 no integer flags exist here, none are touched
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      result_reg <= 32'h0;
      address_reg <= 32'h0;
      newBase_reg <= 32'h0;
      lspAct_reg <= 1'b0;
      ctxAct_reg <= 1'b0;
      save_reg <= 1'b0;
      clear_reg <= 1'b0;
      reload_reg <= 1'b0;
      undef_reg <= 1'b0;
      divz_reg <= 1'b0;
    end else begin
      save_reg <= 1'b0;
      clear_reg <= 1'b0;
      reload_reg <= 1'b0;
      if (fop >= fp_exec_pkg::OP_FMA && fop <= fp_exec_pkg::OP_FNMS &&
          opcode_reg[31]) begin
        result_reg <= fmaRes;
      end
      if (wrOp) begin
        undef_reg <= 1'b0;
        divz_reg <= 1'b0;
        if (isLazy && !secure) begin
          // RL22 undefined in non-secure
          undef_reg <= 1'b1;
        end else if (isLazy && (!fpExt || !sfpa)) begin
          // RL21 RL22 behaves as no-op
          undef_reg <= 1'b0;
        end else if (opCode == fp_exec_pkg::OP_LAZY_STORE) begin
          lspAct_reg <= ctrl_reg[`CTRL_LSPEN_BIT];
          ctxAct_reg <= 1'b0;
        end else if (opCode == fp_exec_pkg::OP_LAZY_RESTORE) begin
          // RL17 cancel pending; RL18 otherwise reload
          if (lspAct_reg) lspAct_reg <= 1'b0;
          else reload_reg <= 1'b1;
          // RL19 context active
          ctxAct_reg <= 1'b1;
        end else if (isFpOp) begin
          // RL20 save and clear pulse together, in the same cycle as the first FP op
          if (lspAct_reg) begin
            save_reg <= 1'b1;
            clear_reg <= 1'b1;
            lspAct_reg <= 1'b0;
          end
          case (opCode)
            fp_exec_pkg::OP_TO_FIXED: result_reg <= toFixed;
            fp_exec_pkg::OP_FROM_FIXED: result_reg <= fromFixed;
            fp_exec_pkg::OP_DIV: begin
              result_reg <= divRes;
              divz_reg <= bZero && !aZero && !aNan && !aInf;
            end
            fp_exec_pkg::OP_LDM_IA: begin
              address_reg <= iaAddr;
              if (pwdata[`OP_WB_BIT]) newBase_reg <= iaBase;
              else newBase_reg <= opD_reg;
            end
            fp_exec_pkg::OP_LDM_DB: begin
              address_reg <= dbAddr;
              // RL13 write-back forced
              newBase_reg <= dbAddr;
            end
            fp_exec_pkg::OP_LDR: address_reg <= ldrAddr;
            default: begin
            end
          endcase
        end
      end
    end
  end
endmodule : fp_convert_fma_lazy_state

// File: verif/fp_convert_fma_lazy_state_asserts.sv
// Concurrent checks on the APB ports of the floating-point execution block.
// Assumes the register map and opcode fields of the shared constants header.
`include "fp_exec_cfg.svh"
`timescale 1ns/100ps
module fp_convert_fma_lazy_state_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // Shadow of what software wrote
  // ------------------------------------------------------------
  logic [31:0] opReg, baseReg;
  logic freshReg; // Opcode newer than base and control writes
  wire wrDone = psel && penable && pwrite;
  wire rdDone = psel && penable && !pwrite;
  wire wrOp = wrDone && paddr == `ADDR_OPCODE;
  wire wrBase = wrDone && (paddr == `ADDR_BASE || paddr == `ADDR_OPD);
  wire wrCtrl = wrDone && paddr == `ADDR_CTRL;
  wire [3:0] code = opReg[3:0];
  wire [31:0] span = {24'h0, opReg[21:16], 2'h0};
  wire [31:0] imm = {22'h0, opReg[29:22], 2'h0};
  wire rdAddr = rdDone && freshReg && paddr == `ADDR_ADDRESS;
  // Shadow registers follow completed writes only
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      opReg <= 32'h0;
      baseReg <= 32'h0;
      freshReg <= 1'b0;
    end else begin
      opReg <= wrOp ? pwdata : opReg;
      baseReg <= wrBase ? pwdata : baseReg;
      freshReg <= wrOp || (freshReg && !wrBase && !wrCtrl);
    end
  end
  chk_zero_wait: assert property (psel && penable |-> pready) else $error("pready low");
  chk_no_error: assert property (psel |-> !pslverr) else $error("pslverr raised");
  chk_signed_fill: assert property (rdDone && freshReg && paddr == `ADDR_RESULT && code == 4'h0
    && opReg[4] && opReg[5] |-> prdata[31:16] == {16{prdata[15]}}) else $error("no sign fill");
  chk_unsigned_fill: assert property (rdDone && freshReg && paddr == `ADDR_RESULT
    && code == 4'h0 && !opReg[4] && opReg[5] |-> prdata[31:16] == 16'h0) else $error("no zero fill");
  chk_ia_start: assert property (rdAddr && code == 4'h7 |-> prdata == baseReg)
    else $error("increment-after start wrong");
  chk_db_start: assert property (rdAddr && code == 4'h8 |-> prdata == baseReg - span)
    else $error("decrement-before start wrong");
  chk_db_writeback: assert property (rdDone && freshReg && paddr == `ADDR_NEWBASE
    && code == 4'h8 |-> prdata == baseReg - span) else $error("decrement-before base wrong");
  chk_single_offset: assert property (rdAddr && code == 4'h9
    |-> prdata == (opReg[15] ? baseReg - imm : baseReg + imm)) else $error("offset wrong");
  cover property (rdAddr && code == 4'h7);
  cover property (rdAddr && code == 4'h8);
  cover property (rdDone && paddr == `ADDR_STATUS && prdata[2]);
endmodule : fp_convert_fma_lazy_state_asserts
bind fp_convert_fma_lazy_state fp_convert_fma_lazy_state_asserts u_fp_convert_fma_lazy_state_asserts (
  .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

// File: verif/apb_master_model.sv
// APB master standing in for the core that issues work to the block.
// Assumes callers enter its task just after a rising clock edge.
`timescale 1ns/100ps
module apb_master_model (
  // Clock
  input wire logic ref_clk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end
  // One transfer; request held until pready is seen at an edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic ok);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Wait for pready; only the watchdog ends a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    ok = (pready === 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show garbage, not the last value
    paddr <= ~a;
    pwdata <= ~d;
    @(posedge ref_clk);
  endtask : xfer
endmodule : apb_master_model

// File: verif/fp_convert_fma_lazy_state_bench.sv
// Self-checking bench for the floating-point execution block.
// Assumes the APB master model and the shared constants header.
`include "fp_exec_cfg.svh"
`timescale 1ns/100ps
module fp_convert_fma_lazy_state_bench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  int bad_count = 0;
  int cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  fp_convert_fma_lazy_state u_fp_convert_fma_lazy_state (.ref_clk(ref_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  apb_master_model u_apb_master_model (.ref_clk(ref_clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic ok;
    u_apb_master_model.xfer(1'b1, a, d, q, ok);
    chk("write pready", 32'h1, {31'h0, ok});
  endtask : wr
  task rd(input logic [11:0] a, output logic [31:0] q);
    logic ok;
    u_apb_master_model.xfer(1'b0, a, 32'h0, q, ok);
  endtask : rd
  // Opcode word from its fields
  function automatic logic [31:0] opc(input logic [3:0] c, input logic sg, input logic hf,
    input logic [5:0] fb, input logic [5:0] cnt, input logic [7:0] im, input logic wb,
    input logic sub);
    opc = {2'h0, im, cnt, sub, wb, fb, 2'h0, hf, sg, c};
  endfunction : opc
  // Operands, opcode, settle, then fetch result
  task run_op(input logic [31:0] op, a, b, d, output logic [31:0] q);
    wr(`ADDR_OPA, a);
    wr(`ADDR_OPB, b);
    wr(`ADDR_OPD, d);
    wr(`ADDR_OPCODE, op);
    repeat (2) @(posedge ref_clk);
    rd(`ADDR_RESULT, q);
  endtask : run_op
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_convert;
    logic [31:0] q;
    run_op(opc(fp_exec_pkg::OP_TO_FIXED, 1, 0, 0, 0, 0, 0, 0), 32'hc0200000, 0, 0, q);
    chk("s32 of -2.5", 32'hfffffffe, q);
    run_op(opc(fp_exec_pkg::OP_TO_FIXED, 1, 1, 0, 0, 0, 0, 0), 32'hc0200000, 0, 0, q);
    chk("s16 of -2.5", 32'hfffffffe, q);
    run_op(opc(fp_exec_pkg::OP_TO_FIXED, 0, 1, 1, 0, 0, 0, 0), 32'h40300000, 0, 0, q);
    chk("u16 of 2.75 fbits 1", 32'h00000005, q);
    run_op(opc(fp_exec_pkg::OP_FROM_FIXED, 0, 1, 0, 0, 0, 0, 0), 32'hffff0003, 0, 0, q);
    chk("u16 high bits ignored", 32'h40400000, q);
    run_op(opc(fp_exec_pkg::OP_FROM_FIXED, 0, 0, 0, 0, 0, 0, 0), 32'h01000003, 0, 0, q);
    chk("u32 tie to even", 32'h4b800002, q);
    $display("test convert done");
  endtask : t_convert
  task t_divide;
    logic [31:0] q;
    run_op(opc(fp_exec_pkg::OP_DIV, 0, 0, 0, 0, 0, 0, 0), 32'h40c00000, 32'h40000000, 0, q);
    chk("6 over 2", 32'h40400000, q);
    run_op(opc(fp_exec_pkg::OP_DIV, 0, 0, 0, 0, 0, 0, 0), 32'h3f800000, 32'h0, 0, q);
    chk("1 over 0", 32'h7f800000, q);
    rd(`ADDR_STATUS, q);
    chk("divide by zero flag", 32'h1, {31'h0, q[7]});
    $display("test divide done");
  endtask : t_divide
  task t_fused;
    logic [31:0] q;
    logic [31:0] want [4] = '{32'h40e00000, 32'hc0a00000, 32'hc0e00000, 32'h40a00000};
    for (int k = 0; k < 4; k++) begin
      run_op(opc(4'(fp_exec_pkg::OP_FMA) + 4'(k), 0, 0, 0, 0, 0, 0, 0) | 32'h80000000,
        32'h40000000, 32'h40400000, 32'h3f800000, q);
      chk("fused 2 3 1", want[k], q);
    end
    // Product kept exact: a rounded product would cancel to zero
    run_op(opc(fp_exec_pkg::OP_FMA, 0, 0, 0, 0, 0, 0, 0) | 32'h80000000,
      32'h3f800800, 32'h3f800800, 32'hbf801000, q);
    chk("fused exact product", 32'h33800000, q);
    $display("test fused done");
  endtask : t_fused
  task ld(input logic [31:0] op, input logic [31:0] base, ea, nb, input logic wbk);
    logic [31:0] q;
    wr(`ADDR_BASE, base);
    wr(`ADDR_OPCODE, op);
    repeat (2) @(posedge ref_clk);
    rd(`ADDR_ADDRESS, q);
    chk("first load address", ea, q);
    if (wbk) begin
      rd(`ADDR_NEWBASE, q);
      chk("written back base", nb, q);
    end
  endtask : ld
  task t_loads;
    ld(opc(fp_exec_pkg::OP_LDM_IA, 0, 0, 0, 3, 0, 1, 0), 32'h1000, 32'h1000, 32'h100c, 1);
    ld(opc(fp_exec_pkg::OP_LDM_DB, 0, 0, 0, 3, 0, 0, 0), 32'h1000, 32'h0ff4, 32'h0ff4, 1);
    ld(opc(fp_exec_pkg::OP_LDR, 0, 0, 0, 0, 8'hff, 0, 0), 32'h2000, 32'h23fc, 0, 0);
    ld(opc(fp_exec_pkg::OP_LDR, 0, 0, 0, 0, 8'hff, 0, 1), 32'h2000, 32'h1c04, 0, 0);
    $display("test loads done");
  endtask : t_loads
  task lazy(input logic [31:0] ctrl, input logic [3:0] code, output logic [31:0] st);
    wr(`ADDR_CTRL, ctrl);
    wr(`ADDR_OPCODE, opc(code, 0, 0, 0, 0, 0, 0, 0));
    repeat (2) @(posedge ref_clk);
    rd(`ADDR_STATUS, st);
  endtask : lazy
  task t_lazy;
    logic [31:0] q;
    lazy(32'hf, fp_exec_pkg::OP_LAZY_STORE, q);
    chk("pending after store", 32'h1, {31'h0, q[2]});
    run_op(opc(fp_exec_pkg::OP_DIV, 0, 0, 0, 0, 0, 0, 0), 32'h40c00000, 32'h40000000, 0, q);
    rd(`ADDR_STATUS, q);
    chk("pending after save", 32'h0, {31'h0, q[2]});
    lazy(32'hf, fp_exec_pkg::OP_LAZY_STORE, q);
    lazy(32'hf, fp_exec_pkg::OP_LAZY_RESTORE, q);
    chk("pending after restore", 32'h0, {31'h0, q[2]});
    chk("context active", 32'h1, {31'h0, q[3]});
    lazy(32'hd, fp_exec_pkg::OP_LAZY_STORE, q);
    chk("store with fp unused", 32'h0, {31'h0, q[2]});
    lazy(32'h7, fp_exec_pkg::OP_LAZY_STORE, q);
    chk("store without extension", 32'h0, {31'h0, q[2]});
    lazy(32'hb, fp_exec_pkg::OP_LAZY_STORE, q);
    chk("non-secure store undefined", 32'h1, {31'h0, q[1]});
    rd(12'h0fc, q);
    chk("unmapped read", 32'h0, q);
    $display("test lazy done");
  endtask : t_lazy
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_convert;
    t_divide;
    t_fused;
    t_loads;
    t_lazy;
    close_out;
  end
  // Watchdog well beyond the hundred or so transfers above
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("BAD watchdog expected finish seen hang");
    close_out;
  end
endmodule : fp_convert_fma_lazy_state_bench
